// [rtl/crs_sequencer.sv]
// Sequencer top with AXI4-Lite registers.
// Assumes analog comparator flags; drives the power stage.
//
// Decided for this implementation: register access over AXI4-Lite and the address map.
`timescale 1ns/10ps
module crs_sequencer #(
    parameter int PGDLY_CYC = crs_pkg::PGDLY_CYC,
    parameter int MASK_CYC = crs_pkg::MASK_CYC
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic regulator_enable_in,
    input wire logic supply_good_flag,
    input wire logic stop_request_n,
    input wire logic sleep_request,
    input wire logic diode_emulation_enable_n,
    input wire logic [crs_pkg::VW-1:0] voltage_code_inputs,
    input wire logic overVoltTrip,
    input wire logic windowOk,
    input wire logic nearZero,
    input wire logic zeroCross,
    input wire logic rampDone,
    input wire logic pwmHigh,
    output logic clockEnableN,
    output logic power_good_out,
    output logic powerGoodOe,
    output logic highSideBlock,
    output logic lowSideForce,
    output logic lowSideBlock,
    output crs_pkg::crs_ss_t softStartMode,
    output crs_pkg::crs_ref_t refSelect,
    output logic diodeEmulActive,
    output logic irq,
    input wire logic awvalid,
    output logic awready,
    input wire logic [crs_pkg::AW-1:0] awaddr,
    input wire logic [2:0] awprot,
    input wire logic wvalid,
    output logic wready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    output logic bvalid,
    input wire logic bready,
    output logic [1:0] bresp,
    input wire logic arvalid,
    output logic arready,
    input wire logic [crs_pkg::AW-1:0] araddr,
    input wire logic [2:0] arprot,
    output logic rvalid,
    input wire logic rready,
    output logic [31:0] rdata,
    output logic [1:0] rresp
);
    typedef struct packed {
        crs_pkg::crs_seq_t seq;
        crs_pkg::crs_drive_t drv;
        logic [1:0] ctrl;
        logic [crs_pkg::NIRQ-1:0] irqSt;
        logic [crs_pkg::NIRQ-1:0] irqEn;
        logic irq;
        logic [crs_pkg::VW-1:0] prevCode;
        crs_pkg::crs_ref_t prevRef;
        logic pgEn;
        logic pgGood;
        logic lsCut;
        logic bootGo;
        logic pgGo;
        logic maskGo;
        logic tmClear;
        logic awready;
        logic awHeld;
        logic [crs_pkg::AW-1:0] awAddr;
        logic wready;
        logic wHeld;
        logic [31:0] wData;
        logic wLow;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
    } crs_top_st_t;
    crs_top_st_t st_q;
    crs_top_st_t st_d;
    crs_pkg::crs_pins_t pinRaw;
    crs_pkg::crs_pins_t pin;
    logic bootDone;
    logic pgDone;
    logic maskRun;
    // ==========
    // Input synchronisers
    assign pinRaw = {regulator_enable_in, supply_good_flag, stop_request_n,
        sleep_request, diode_emulation_enable_n, voltage_code_inputs,
        overVoltTrip, windowOk, nearZero, zeroCross, rampDone, pwmHigh};
    crs_sync #(
        .W($bits(crs_pkg::crs_pins_t))
    ) u_sync (
        .clk(clk),
        .rst_n(rst_n),
        .din(pinRaw),
        .dout(pin)
    );
    // ==========
    // Timers
    crs_timer #(
        .W(crs_pkg::TW)
    ) u_boot (
        .clk(clk),
        .rst_n(rst_n),
        .start(st_q.bootGo),
        .clear(st_q.tmClear),
        .load(crs_pkg::TW'(crs_pkg::BOOT_CYC)),
        .running(),
        .done(bootDone)
    );
    crs_timer #(
        .W(crs_pkg::TW)
    ) u_pgdly (
        .clk(clk),
        .rst_n(rst_n),
        .start(st_q.pgGo),
        .clear(st_q.tmClear),
        .load(crs_pkg::TW'(PGDLY_CYC)),
        .running(),
        .done(pgDone)
    );
    crs_timer #(
        .W(crs_pkg::TW)
    ) u_mask (
        .clk(clk),
        .rst_n(rst_n),
        .start(st_q.maskGo),
        .clear(st_q.tmClear),
        .load(crs_pkg::TW'(MASK_CYC)),
        .running(maskRun),
        .done()
    );
    // ==========
    // Register read mux
    function automatic logic [31:0] readReg(
        input logic [crs_pkg::AW-1:0] a,
        input crs_top_st_t s
    );
        logic [31:0] r;
        r = '0;
        case (a)
            crs_pkg::ADDR_CTRL: begin
                r[1:0] = s.ctrl;
            end
            crs_pkg::ADDR_STATUS: begin
                r[crs_pkg::ST_SEQ_LSB +: 3] = s.seq;
                r[crs_pkg::ST_REF_LSB +: 3] = s.drv.refSel;
                r[crs_pkg::ST_CLK_BIT] = s.drv.clkEnN;
                r[crs_pkg::ST_PG_BIT] = s.pgGood;
                r[crs_pkg::ST_DE_BIT] = s.drv.deActive;
            end
            crs_pkg::ADDR_IRQ_ST: begin
                r[crs_pkg::NIRQ-1:0] = s.irqSt;
            end
            crs_pkg::ADDR_IRQ_EN: begin
                r[crs_pkg::NIRQ-1:0] = s.irqEn;
            end
            crs_pkg::ADDR_VCODE: begin
                r[crs_pkg::VW-1:0] = s.prevCode;
            end
            default: begin
                r = '0;
            end
        endcase
        return r;
    endfunction
    function automatic logic mapped(input logic [crs_pkg::AW-1:0] a);
        return a == crs_pkg::ADDR_CTRL || a == crs_pkg::ADDR_STATUS ||
            a == crs_pkg::ADDR_IRQ_ST || a == crs_pkg::ADDR_IRQ_EN ||
            a == crs_pkg::ADDR_IRQ_CLR || a == crs_pkg::ADDR_VCODE;
    endfunction
    // ==========
    // Next state
    always_comb begin
        logic en;
        logic [crs_pkg::NIRQ-1:0] ev;
        logic [crs_pkg::NIRQ-1:0] clr;
        crs_pkg::crs_ref_t modeRef;
        logic changed;
        en = 1'b0;
        ev = '0;
        clr = '0;
        modeRef = crs_pkg::REF_VID;
        changed = 1'b0;
        st_d = st_q;
        st_d.bootGo = 1'b0;
        st_d.pgGo = 1'b0;
        st_d.maskGo = 1'b0;
        st_d.tmClear = 1'b0;
        en = pin.regEnable & ~st_q.ctrl[crs_pkg::CTRL_OFF_BIT];
        // (R12) Both asserted selects sleep
        if (!pin.stopN && pin.sleep) begin
            modeRef = crs_pkg::REF_SLEEP;
        // (R11) Stop alone selects stop
        end else if (!pin.stopN) begin
            modeRef = crs_pkg::REF_STOP;
        end
        changed = pin.vcode != st_q.prevCode || modeRef != st_q.prevRef;
        case (st_q.seq)
            crs_pkg::SQ_OFF: begin
                // (R2) New power up on enable
                if (en) begin
                    st_d.seq = crs_pkg::SQ_START;
                end
            end
            crs_pkg::SQ_START: begin
                // (R6) Boot delay from supply good
                if (pin.rampDone && pin.supplyGood) begin
                    st_d.seq = crs_pkg::SQ_BOOT;
                    st_d.bootGo = 1'b1;
                end
            end
            crs_pkg::SQ_BOOT: begin
                // (R7) Clock enable and VOLTAGE_CODE_INPUTS level in the same cycle
                if (bootDone) begin
                    st_d.seq = crs_pkg::SQ_RUN;
                    st_d.pgGo = 1'b1;
                    st_d.maskGo = 1'b1;
                    st_d.prevCode = pin.vcode;
                    st_d.prevRef = modeRef;
                end
            end
            crs_pkg::SQ_RUN: begin
                // (R9) Mask on code change
                if (changed) begin
                    st_d.maskGo = 1'b1;
                    st_d.prevCode = pin.vcode;
                    st_d.prevRef = modeRef;
                    ev[crs_pkg::IRQ_MODE] = 1'b1;
                end
                // (R8) Power good enable
                if (pgDone && !st_q.pgEn) begin
                    st_d.pgEn = 1'b1;
                    ev[crs_pkg::IRQ_READY] = 1'b1;
                end
            end
            crs_pkg::SQ_STOP: begin
                // (R5) Near zero clamp
                if (pin.nearZero) begin
                    st_d.seq = crs_pkg::SQ_ZERO;
                end else if (en) begin
                    st_d.seq = crs_pkg::SQ_START;
                end
            end
            crs_pkg::SQ_ZERO: begin
                if (en) begin
                    st_d.seq = crs_pkg::SQ_START;
                end
            end
            crs_pkg::SQ_FAULT: begin
                // (R2) Enable low clears latch
                if (!en) begin
                    st_d.seq = crs_pkg::SQ_OFF;
                end
            end
            default: begin
                st_d.seq = crs_pkg::SQ_OFF;
            end
        endcase
        // (R4) Enable low starts soft stop
        if (!en && (st_q.seq == crs_pkg::SQ_START ||
                st_q.seq == crs_pkg::SQ_BOOT ||
                st_q.seq == crs_pkg::SQ_RUN)) begin
            st_d.seq = crs_pkg::SQ_STOP;
        end
        // (R16) Fault beats all else
        if (pin.ovTrip && st_q.seq != crs_pkg::SQ_OFF &&
                st_q.seq != crs_pkg::SQ_FAULT) begin
            st_d.seq = crs_pkg::SQ_FAULT;
            ev[crs_pkg::IRQ_OVP] = 1'b1;
        end
        if (st_d.seq != crs_pkg::SQ_RUN) begin
            st_d.pgEn = 1'b0;
            st_d.tmClear = st_q.seq == crs_pkg::SQ_RUN;
        end
        // ==========
        // Power stage drive
        st_d.drv.clkEnN = st_d.seq != crs_pkg::SQ_RUN;
        st_d.drv.hsBlock = 1'b0;
        st_d.drv.lsForce = 1'b0;
        st_d.drv.ssMode = crs_pkg::SS_HOLD;
        st_d.drv.refSel = crs_pkg::REF_ZERO;
        case (st_d.seq)
            crs_pkg::SQ_OFF: begin
                st_d.drv.hsBlock = 1'b1;
                st_d.drv.ssMode = crs_pkg::SS_DUMP;
            end
            crs_pkg::SQ_START: begin
                // (R3) Charge soft start ramp
                st_d.drv.ssMode = crs_pkg::SS_START;
                st_d.drv.refSel = crs_pkg::REF_BOOT;
            end
            crs_pkg::SQ_BOOT: begin
                st_d.drv.refSel = crs_pkg::REF_BOOT;
            end
            crs_pkg::SQ_RUN: begin
                st_d.drv.refSel = modeRef;
                // (R10) Slew current on transition
                if (st_d.maskGo || maskRun) begin
                    st_d.drv.ssMode = crs_pkg::SS_SLEW;
                end
            end
            crs_pkg::SQ_STOP: begin
                // (R4) Sink ramp down
                st_d.drv.ssMode = crs_pkg::SS_SINK;
                st_d.drv.refSel = crs_pkg::REF_BOOT;
            end
            default: begin
                // (R1) Fault or clamp drive
                st_d.drv.hsBlock = 1'b1;
                st_d.drv.lsForce = 1'b1;
                st_d.drv.ssMode = crs_pkg::SS_DUMP;
            end
        endcase
        // (R13) Diode emulation gate
        st_d.drv.deActive = st_d.seq == crs_pkg::SQ_RUN &&
            modeRef == crs_pkg::REF_SLEEP && !pin.deEnN &&
            st_q.ctrl[crs_pkg::CTRL_DE_BIT];
        // (R14) Cut low side on reversal
        if (!st_d.drv.deActive || pin.pwmHigh) begin
            st_d.lsCut = 1'b0;
        end else if (pin.zeroCross) begin
            st_d.lsCut = 1'b1;
        end
        st_d.drv.lsBlock = st_d.lsCut;
        // (R15) Window or mask
        st_d.pgGood = st_d.pgEn && (maskRun || st_d.maskGo || pin.windowOk);
        if (st_q.pgGood && !st_d.pgGood && st_d.seq == crs_pkg::SQ_RUN) begin
            ev[crs_pkg::IRQ_PGFALL] = 1'b1;
        end
        st_d.drv.pgOut = 1'b0;
        st_d.drv.pgOe = ~st_d.pgGood;
        // ==========
        // AXI4-Lite write
        if (awvalid && st_q.awready) begin
            st_d.awHeld = 1'b1;
            st_d.awAddr = awaddr;
            st_d.awready = 1'b0;
        end
        if (wvalid && st_q.wready) begin
            st_d.wHeld = 1'b1;
            st_d.wData = wdata;
            st_d.wLow = wstrb[0];
            st_d.wready = 1'b0;
        end
        if (st_q.awHeld && st_q.wHeld && !st_q.bvalid) begin
            st_d.awHeld = 1'b0;
            st_d.wHeld = 1'b0;
            st_d.bvalid = 1'b1;
            st_d.bresp = mapped(st_q.awAddr) ? crs_pkg::RESP_OKAY :
                crs_pkg::RESP_SLVERR;
            if (st_q.wLow) begin
                case (st_q.awAddr)
                    crs_pkg::ADDR_CTRL: begin
                        st_d.ctrl = st_q.wData[1:0];
                    end
                    crs_pkg::ADDR_IRQ_EN: begin
                        st_d.irqEn = st_q.wData[crs_pkg::NIRQ-1:0];
                    end
                    crs_pkg::ADDR_IRQ_CLR: begin
                        clr = st_q.wData[crs_pkg::NIRQ-1:0];
                    end
                    default: begin
                        clr = '0;
                    end
                endcase
            end
        end
        if (st_q.bvalid && bready) begin
            st_d.bvalid = 1'b0;
            st_d.awready = 1'b1;
            st_d.wready = 1'b1;
        end
        // ==========
        // AXI4-Lite read
        if (arvalid && st_q.arready) begin
            st_d.arready = 1'b0;
            st_d.rvalid = 1'b1;
            st_d.rdata = readReg(araddr, st_q);
            st_d.rresp = mapped(araddr) ? crs_pkg::RESP_OKAY :
                crs_pkg::RESP_SLVERR;
        end
        if (st_q.rvalid && rready) begin
            st_d.rvalid = 1'b0;
            st_d.arready = 1'b1;
        end
        // ==========
        // Interrupts, set beats clear
        st_d.irqSt = (st_q.irqSt & ~clr) | ev;
        st_d.irq = |(st_d.irqSt & st_d.irqEn);
    end
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            st_q <= '0;
            st_q.seq <= crs_pkg::SQ_OFF;
            st_q.ctrl <= crs_pkg::CTRL_RST;
            st_q.drv.clkEnN <= 1'b1;
            st_q.drv.pgOe <= 1'b1;
            st_q.drv.hsBlock <= 1'b1;
            st_q.drv.ssMode <= crs_pkg::SS_DUMP;
            st_q.prevRef <= crs_pkg::REF_VID;
            st_q.awready <= 1'b1;
            st_q.wready <= 1'b1;
            st_q.arready <= 1'b1;
        end else begin
            st_q <= st_d;
        end
    end
    // ==========
    // Outputs
    assign clockEnableN = st_q.drv.clkEnN;
    assign power_good_out = st_q.drv.pgOut;
    assign powerGoodOe = st_q.drv.pgOe;
    assign highSideBlock = st_q.drv.hsBlock;
    assign lowSideForce = st_q.drv.lsForce;
    assign lowSideBlock = st_q.drv.lsBlock;
    assign softStartMode = st_q.drv.ssMode;
    assign refSelect = st_q.drv.refSel;
    assign diodeEmulActive = st_q.drv.deActive;
    assign irq = st_q.irq;
    assign awready = st_q.awready;
    assign wready = st_q.wready;
    assign bvalid = st_q.bvalid;
    assign bresp = st_q.bresp;
    assign arready = st_q.arready;
    assign rvalid = st_q.rvalid;
    assign rdata = st_q.rdata;
    assign rresp = st_q.rresp;
endmodule

// [pkg/crs_pkg.sv]
// Constants and types of the core regulator sequencer.
// Assumes a 100 MHz clock and analog comparator flags.
// How it works
// (R1) Above 120% of overvoltage setting: high side off, low side on.
// (R2) Overvoltage fault latches until power cycle or enable toggle.
// (R3) Enable starts the 20uA soft start charge ramp.
// (R4) Enable low sinks soft start at 45uA; output follows.
// (R5) Soft stop below 300mV: high side off, low side held on.
// (R6) Hold boot level until 20us after supply good.
// (R7) Boot delay over: clock enable low, then selected level; the code switches clock enable and level in the same cycle.
// (R8) Power good enabled 5ms after clock enable asserts.
// (R9) Code or mode change masks power good 130us, forcing it high.
// (R10) Transitions slew soft start at 350uA.
// (R11) Stop without sleep: stop level reference, mask applied.
// (R12) Stop and sleep: sleep level reference, mask applied.
// (R13) Diode emulation only in sleep with its low enable asserted.
// (R14) In diode emulation a current reversal cuts low side for the cycle.
// (R15) Enabled power good high only inside the 88-112% window; the code also holds it high while the mask of R9 runs.
// (R16) Latched overvoltage fault overrides every mode and request.
package crs_pkg;
    // ==========
    // Timing
    localparam int CLK_NS = 10;
    localparam int BOOT_NS = 20_000;
    localparam int PGDLY_NS = 5_000_000;
    localparam int MASK_NS = 130_000;
    localparam int BOOT_CYC = (BOOT_NS + CLK_NS - 1) / CLK_NS;
    localparam int PGDLY_CYC = (PGDLY_NS + CLK_NS - 1) / CLK_NS;
    localparam int MASK_CYC = (MASK_NS + CLK_NS - 1) / CLK_NS;
    localparam int TW = 20;
    localparam int VW = 6;
    localparam int AW = 8;
    localparam int NIRQ = 4;
    // ==========
    // Register map and fields
    localparam logic [AW-1:0] ADDR_CTRL = 8'h00;
    localparam logic [AW-1:0] ADDR_STATUS = 8'h04;
    localparam logic [AW-1:0] ADDR_IRQ_ST = 8'h08;
    localparam logic [AW-1:0] ADDR_IRQ_EN = 8'h0C;
    localparam logic [AW-1:0] ADDR_IRQ_CLR = 8'h10;
    localparam logic [AW-1:0] ADDR_VCODE = 8'h14;
    localparam int CTRL_DE_BIT = 0;
    localparam int CTRL_OFF_BIT = 1;
    localparam logic [1:0] CTRL_RST = 2'h1;
    localparam int ST_SEQ_LSB = 0;
    localparam int ST_REF_LSB = 4;
    localparam int ST_CLK_BIT = 8;
    localparam int ST_PG_BIT = 9;
    localparam int ST_DE_BIT = 10;
    localparam int IRQ_OVP = 0;
    localparam int IRQ_PGFALL = 1;
    localparam int IRQ_READY = 2;
    localparam int IRQ_MODE = 3;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    // ==========
    // Types
    typedef enum logic [2:0] {
        SQ_OFF, SQ_START, SQ_BOOT, SQ_RUN, SQ_STOP, SQ_ZERO, SQ_FAULT
    } crs_seq_t;
    typedef enum logic [2:0] {
        REF_ZERO, REF_BOOT, REF_VID, REF_STOP, REF_SLEEP
    } crs_ref_t;
    typedef enum logic [2:0] {
        SS_HOLD, SS_START, SS_SINK, SS_SLEW, SS_DUMP
    } crs_ss_t;
    typedef struct packed {
        logic regEnable;
        logic supplyGood;
        logic stopN;
        logic sleep;
        logic deEnN;
        logic [VW-1:0] vcode;
        logic ovTrip;
        logic windowOk;
        logic nearZero;
        logic zeroCross;
        logic rampDone;
        logic pwmHigh;
    } crs_pins_t;
    typedef struct packed {
        logic clkEnN;
        logic pgOe;
        logic pgOut;
        logic hsBlock;
        logic lsForce;
        logic lsBlock;
        crs_ss_t ssMode;
        crs_ref_t refSel;
        logic deActive;
    } crs_drive_t;
endpackage

// [rtl/crs_sync.sv]
// Three flop input synchroniser with agreement filter.
// Assumes asynchronous inputs; stages two and three must agree.
`timescale 1ns/10ps
module crs_sync #(
    parameter int W = 1
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [W-1:0] din,
    output logic [W-1:0] dout
);
    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
        logic [W-1:0] s3;
        logic [W-1:0] q;
    } crs_sync_st_t;
    crs_sync_st_t st_q;
    crs_sync_st_t st_d;
    logic [W-1:0] agree;
    // ==========================================
    // Per bit agreement
    for (genvar i = 0; i < W; i++) begin : g_bit
        assign agree[i] = (st_q.s2[i] == st_q.s3[i]) ? st_q.s3[i] : st_q.q[i];
    end
    always_comb begin
        st_d = st_q;
        st_d.s1 = din;
        st_d.s2 = st_q.s1;
        st_d.s3 = st_q.s2;
        st_d.q = agree;
    end
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end
    assign dout = st_q.q;
endmodule

// [rtl/crs_timer.sv]
// One shot down counter; done holds until start or clear.
// Assumes load is at least one.
`timescale 1ns/10ps
module crs_timer #(
    parameter int W = 20
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic start,
    input wire logic clear,
    input wire logic [W-1:0] load,
    output logic running,
    output logic done
);
    typedef struct packed {
        logic [W-1:0] cnt;
        logic run;
        logic done;
    } crs_timer_st_t;
    crs_timer_st_t st_q;
    crs_timer_st_t st_d;
    always_comb begin
        st_d = st_q;
        if (clear) begin
            st_d.run = 1'b0;
            st_d.done = 1'b0;
        end else if (start) begin
            st_d.cnt = load;
            st_d.run = 1'b1;
            st_d.done = 1'b0;
        end else if (st_q.run) begin
            st_d.cnt = st_q.cnt - W'(1);
            if (st_q.cnt == W'(1)) begin
                st_d.run = 1'b0;
                st_d.done = 1'b1;
            end
        end
    end
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end
    assign running = st_q.run;
    assign done = st_q.done;
endmodule

// [test/crs_properties.sv]
// Port assertions for the core regulator sequencer.
// Assumes pin inputs take three to six cycles to act.
`timescale 1ns/10ps
module crs_checker #(
    parameter int PGDLY_CYC = 50,
    parameter int MASK_CYC = 20
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic regulator_enable_in,
    input wire logic overVoltTrip,
    input wire logic windowOk,
    input wire logic nearZero,
    input wire logic zeroCross,
    input wire logic clockEnableN,
    input wire logic powerGoodOe,
    input wire logic highSideBlock,
    input wire logic lowSideForce,
    input wire logic lowSideBlock,
    input wire logic diodeEmulActive,
    input wire crs_pkg::crs_ss_t softStartMode
);
    int runCnt_q;
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    // ==========
    // Run counter and checks
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) runCnt_q <= 0;
        else runCnt_q <= clockEnableN ? 0 : runCnt_q + 1;
    end
    chk_ovp_safe: assert property (
        $rose(overVoltTrip) && !clockEnableN |-> ##[3:6] (highSideBlock &&
        lowSideForce && softStartMode == crs_pkg::SS_DUMP))
        else $error("No overvoltage clamp");
    chk_soft_start: assert property (
        $rose(regulator_enable_in) |-> ##[3:6]
        softStartMode == crs_pkg::SS_START) else $error("No soft start");
    chk_soft_stop: assert property (
        $fell(regulator_enable_in) && !clockEnableN |->
        ##[3:6] softStartMode == crs_pkg::SS_SINK) else $error("No soft stop");
    chk_zero_clamp: assert property (
        $rose(nearZero) && softStartMode == crs_pkg::SS_SINK |->
        ##[3:6] (highSideBlock && lowSideForce)) else $error("No zero clamp");
    chk_pg_hold: assert property (
        runCnt_q > MASK_CYC + 4 && runCnt_q < PGDLY_CYC - 2 |-> powerGoodOe)
        else $error("Early power good");
    chk_pg_mask: assert property (
        $fell(clockEnableN) |-> ##2 (powerGoodOe &&
        softStartMode == crs_pkg::SS_SLEW) [*8]) else $error("No mask");
    chk_zero_cut: assert property (
        diodeEmulActive && $rose(zeroCross) |-> ##[3:6] lowSideBlock)
        else $error("Low side not cut");
    chk_pg_window: assert property (
        (!windowOk && softStartMode != crs_pkg::SS_SLEW) [*6] |-> powerGoodOe)
        else $error("Power good outside window");
endmodule
bind crs_sequencer crs_checker #(.PGDLY_CYC(PGDLY_CYC), .MASK_CYC(MASK_CYC))
    crs_checker_i (.*);

// [test/crs_host_model.sv]
// Processor side model of the request pins.
// Assumes the bench changes requests just after clock edges.
`timescale 1ns/10ps
module crs_host_model (
    input wire logic wantOn,
    input wire logic wantDe,
    input wire logic [1:0] mode,
    output logic regulator_enable_in,
    output logic stop_request_n,
    output logic sleep_request,
    output logic diode_emulation_enable_n
);
    // ==========
    // Request pins
    // enable toggles restart
    assign regulator_enable_in = wantOn;
    assign stop_request_n = mode == 2'h0;
    assign sleep_request = mode == 2'h2;
    assign diode_emulation_enable_n = !(wantDe && sleep_request);
endmodule

// [test/crs_sequencer_tb.sv]
// Self-checking bench for the core regulator sequencer.
// Assumes power good and mask counts shortened to 50 and 20.
`timescale 1ns/10ps
module crs_sequencer_tb;
    logic clk = 0, rst_n = 0, wantOn = 0, wantDe = 0, pwmHigh = 0;
    logic overVoltTrip = 0, windowOk = 0, nearZero = 0, zeroCross = 0;
    logic rampDone = 0, supply_good_flag = 0, bready = 1, rready = 1;
    logic awvalid = 0, wvalid = 0, arvalid = 0;
    logic [1:0] mode = 2'h0;
    logic [5:0] voltage_code_inputs = 6'h00;
    logic [7:0] awaddr = 8'h00, araddr = 8'h00;
    logic [2:0] awprot = 3'h0, arprot = 3'h0;
    logic [3:0] wstrb = 4'hF;
    logic [31:0] wdata = 32'h0000_0000, rdata, d;
    logic [1:0] bresp, rresp, r;
    logic regulator_enable_in, stop_request_n, sleep_request;
    logic diode_emulation_enable_n, clockEnableN, power_good_out, irq;
    logic powerGoodOe, highSideBlock, lowSideForce, lowSideBlock;
    logic diodeEmulActive, awready, wready, bvalid, arready, rvalid;
    crs_pkg::crs_ss_t softStartMode;
    crs_pkg::crs_ref_t refSelect;
    int badCount = 0, comparisons = 0;
    crs_host_model crs_host_model_i (.*);
    crs_sequencer #(.PGDLY_CYC(50), .MASK_CYC(20)) crs_sequencer_i (.*);
    always #5 clk = ~clk;
    // ==========
    // Tasks
    task automatic wt(input int n);
        repeat (n) @(posedge clk);
    endtask
    task automatic chk(input logic [33:0] got, input logic [33:0] exp);
        comparisons++;
        if (got !== exp) begin
            badCount++;
            $display("Error at %0t: saw %h, expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        {awaddr, wdata, awvalid, wvalid} <= {a, v, 2'b11};
        do begin
            @(posedge clk);
            if (awready) awvalid <= 0;
            if (wready) wvalid <= 0;
        end while ((awvalid && !awready) || (wvalid && !wready));
        do @(posedge clk); while (!bvalid);
    endtask
    task automatic rd(input logic [7:0] a);
        {araddr, arvalid} <= {a, 1'b1};
        do @(posedge clk); while (!arready);
        arvalid <= 0;
        do @(posedge clk); while (!rvalid);
        {r, d} = {rresp, rdata};
    endtask
    task automatic test_done;
        $display("Checks %0d, mismatches %0d", comparisons, badCount);
        if (badCount == 0 && comparisons > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    initial begin
        #100_000;
        badCount++;
        test_done;
    end
    // ==========
    // Tests
    initial begin
        wt(2);
        rst_n <= 1;
        wr(crs_pkg::ADDR_IRQ_EN, 32'h0000_0000);
        rd(crs_pkg::ADDR_CTRL);
        chk(d, 32'h0000_0001);
        rd(8'h40);
        chk({r, d}, {2'h2, 32'h0000_0000});
        $display("Register test done");
        wantOn <= 1;
        wt(8);
        chk(softStartMode, crs_pkg::SS_START);
        {rampDone, supply_good_flag} <= 2'b11;
        wt(1990);
        chk(clockEnableN, 1'b1);
        wt(20);
        chk({clockEnableN, refSelect}, {1'b0, crs_pkg::REF_VID});
        chk({powerGoodOe, irq}, 2'b10);
        windowOk <= 1;
        wt(25);
        chk(powerGoodOe, 1'b1);
        wt(30);
        chk(powerGoodOe, 1'b0);
        wr(crs_pkg::ADDR_IRQ_EN, 32'h0000_000F);
        wt(2);
        chk(irq, 1'b1);
        wr(crs_pkg::ADDR_IRQ_CLR, 32'h0000_000F);
        wt(2);
        chk(irq, 1'b0);
        windowOk <= 0;
        wt(8);
        chk({powerGoodOe, irq}, 2'b11);
        $display("Startup test done");
        voltage_code_inputs <= 6'h15;
        wt(8);
        chk(powerGoodOe, 1'b0);
        mode <= 2'h1;
        wt(8);
        chk(refSelect, crs_pkg::REF_STOP);
        {mode, wantDe} <= 3'b101;
        wt(8);
        chk(refSelect, crs_pkg::REF_SLEEP);
        chk(diodeEmulActive, 1'b1);
        zeroCross <= 1;
        wt(8);
        chk(lowSideBlock, 1'b1);
        {zeroCross, pwmHigh, mode} <= 4'b0100;
        wt(8);
        chk({lowSideBlock, diodeEmulActive}, 2'b00);
        $display("Mode test done");
        {wantOn, pwmHigh} <= 2'b00;
        wt(8);
        chk(softStartMode, crs_pkg::SS_SINK);
        nearZero <= 1;
        wt(8);
        chk({highSideBlock, lowSideForce}, 2'b11);
        {nearZero, wantOn} <= 2'b01;
        wt(2030);
        chk(clockEnableN, 1'b0);
        overVoltTrip <= 1;
        wt(8);
        chk({highSideBlock, lowSideForce, clockEnableN}, 3'b111);
        chk(softStartMode, crs_pkg::SS_DUMP);
        {overVoltTrip, mode} <= 3'b010;
        wt(8);
        chk({highSideBlock, clockEnableN, diodeEmulActive}, 3'b110);
        {wantOn, rampDone} <= 2'b00;
        wt(8);
        wantOn <= 1;
        wt(8);
        chk(softStartMode, crs_pkg::SS_START);
        $display("Stop and fault test done");
        test_done;
    end
endmodule
